/* File: include/ext_bus_pkg.sv */
// constants shared by the external memory bus strobe block
// assumes one 100 MHz clock that stands in for the oscillator
`default_nettype none
package ext_bus_pkg;
  // ----------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_PORT0 = 10'h080;
  localparam logic [9:0] IDX_PORT1 = 10'h090;
  localparam logic [9:0] IDX_PORT2 = 10'h0a0;
  localparam logic [9:0] IDX_PORT3 = 10'h0b0;
  localparam logic [9:0] IDX_MODE = 10'h0c0;
  localparam logic [9:0] IDX_XCMD = 10'h0c1;
  localparam logic [9:0] IDX_STATUS = 10'h0c2;
  localparam logic [9:0] IDX_FETCH = 10'h0c3;
  localparam logic [9:0] IDX_STROBE_CTRL = 10'h08e;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_STROBE_OFF = 0;
  localparam int MODE_IDLE = 0;
  localparam int MODE_POWER_DOWN = 1;
  localparam int MODE_EMULATION = 2;
  localparam int MODE_CODE_TABLE = 3;
  localparam int MODE_LOCK1 = 4;
  localparam int MODE_LOCK2 = 5;
  localparam int XCMD_WDATA_LSB = 16;
  localparam int XCMD_WRITE = 24;
  localparam int XCMD_WIDE = 25;
  localparam int STAT_BUSY = 8;
  localparam int STAT_EXT_EXEC = 9;
  localparam int STAT_FETCH_SEL = 10;
  localparam int STAT_IN_RESET = 11;
  localparam int FETCH_BYTE_LSB = 16;
  localparam int PIN_WRITE_STROBE = 6;
  localparam int PIN_READ_STROBE = 7;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PORT_LATCH = 8'hff;
  localparam logic [7:0] RST_STROBE_CTRL = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [15:0] RST_FETCH_ADDR = 16'h0000;
  // ----------------------------------------------------------------
  // timing: machine cycle of twelve oscillator periods
  // ----------------------------------------------------------------
  localparam int OSC_PER_MCYCLE = 12;
  localparam int RESET_MCYCLES = 2;
  localparam int RESET_CLKS = RESET_MCYCLES * OSC_PER_MCYCLE;
  localparam logic [3:0] PH_LAST = 4'(OSC_PER_MCYCLE - 1);
  localparam logic [3:0] PH_HALF = 4'(OSC_PER_MCYCLE / 2);
  localparam logic [3:0] Q_STROBE_ON = 4'h2;
  localparam logic [3:0] Q_SAMPLE = 4'h5;
  localparam logic [3:0] PH_XSTROBE_END = 4'ha;
  localparam logic [15:0] INTERNAL_CODE_TOP = 16'h0fff;
  // ----------------------------------------------------------------
  // kind of the current machine cycle
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CYC_PLAIN = 3'b001,
    CYC_FETCH = 3'b010,
    CYC_XDATA = 3'b100
  } cycle_kind_t;
endpackage
`default_nettype wire

/* File: verilog/pin_qualifier.sv */
// synchronises the reset and fetch-select pins and qualifies reset
// assumes both pins are asynchronous to hclk
`default_nettype none
module pin_qualifier #(
  parameter int HOLD_CLKS = ext_bus_pkg::RESET_CLKS
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // pins
  input wire logic reset_pin,
  input wire logic external_fetch_pin,
  // qualified results
  output logic core_reset,
  output logic fetch_pin_sync
);
  import ext_bus_pkg::*;

  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic [5:0] hold_reg;

  // ----------------------------------------------------------------
  // two-flop synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_reg <= 2'h2;
      sync2_reg <= 2'h2;
    end
    else
    begin
      sync1_reg <= {external_fetch_pin, reset_pin};
      sync2_reg <= sync1_reg;
    end
  end

  assign fetch_pin_sync = sync2_reg[1];

  // ----------------------------------------------------------------
  // reset needs the pin high for two whole machine cycles
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hold_reg <= 6'h0;
      core_reset <= 1'b0;
    end
    else if (!sync2_reg[0])
    begin
      hold_reg <= 6'h0;
      core_reset <= 1'b0;
    end
    else if (hold_reg >= 6'(HOLD_CLKS - 1))
      core_reset <= 1'b1;
    else
      hold_reg <= hold_reg + 6'h1;
  end
endmodule
`default_nettype wire

/* File: verilog/external_memory_bus.sv */
// external memory bus strobes: multiplexed ports, latch strobe,
// code read strobe, data read/write strobes, fetch-select handling
// assumes an AHB-Lite master on hclk; pins are asynchronous
`default_nettype none
module external_memory_bus #(
  parameter logic [15:0] INTERNAL_TOP = ext_bus_pkg::INTERNAL_CODE_TOP
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // control pins
  input wire logic reset_pin,
  input wire logic external_fetch_pin,
  // latch strobe pin
  output logic latch_strobe_program_pin_out,
  output logic latch_strobe_program_pin_oe,
  output logic latch_strobe_program_pin_pullup,
  // code read strobe pin, active low
  output logic code_read_strobe_n_out,
  output logic code_read_strobe_n_oe,
  output logic code_read_strobe_n_pullup,
  // port 0
  input wire logic [7:0] port0_in,
  output logic [7:0] port0_out,
  output logic [7:0] port0_oe,
  // port 1
  output logic [7:0] port1_out,
  output logic [7:0] port1_oe,
  output logic [7:0] port1_pullup,
  // port 2
  output logic [7:0] port2_out,
  output logic [7:0] port2_oe,
  output logic [7:0] port2_pullup,
  // port 3
  output logic [7:0] port3_out,
  output logic [7:0] port3_oe,
  output logic [7:0] port3_pullup
);
  import ext_bus_pkg::*;

  function automatic logic [9:0] reg_index(input logic [31:0] addr);
    reg_index = addr[11:2];
  endfunction

  logic core_reset;
  logic fetch_pin_sync;
  logic [7:0] p0_sync1_reg;
  logic [7:0] p0_sync2_reg;
  logic [3:0] phase_reg;
  cycle_kind_t cyc_reg;
  logic [7:0] strobe_ctrl_reg;
  logic [7:0] mode_reg;
  logic [7:0] p0_latch_reg;
  logic [7:0] p1_latch_reg;
  logic [7:0] high_port_latch_reg;
  logic [7:0] p3_latch_reg;
  logic [15:0] fetch_addr_reg;
  logic [7:0] code_byte_reg;
  logic [15:0] xaddr_reg;
  logic [7:0] xwdata_reg;
  logic xwrite_reg;
  logic xwide_reg;
  logic busy_reg;
  logic [7:0] xread_reg;
  logic fetch_latch_reg;
  logic wr_pend_reg;
  logic [9:0] wr_idx_reg;

  pin_qualifier #(
    .HOLD_CLKS(RESET_CLKS)
  ) u_pins (
    .hclk(hclk),
    .hresetn(hresetn),
    .reset_pin(reset_pin),
    .external_fetch_pin(external_fetch_pin),
    .core_reset(core_reset),
    .fetch_pin_sync(fetch_pin_sync)
  );

  // ----------------------------------------------------------------
  // port 0 input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      p0_sync1_reg <= 8'h00;
      p0_sync2_reg <= 8'h00;
    end
    else
    begin
      p0_sync1_reg <= port0_in;
      p0_sync2_reg <= p0_sync1_reg;
    end
  end

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  logic idle;
  logic power_down;
  logic emulation_mode;
  logic code_table_read;
  logic lock_any;
  logic external_fetch_select;
  logic ext_exec;
  logic is_fetch;
  logic is_xdata;
  logic half;
  logic [3:0] q;
  logic strobe_off;

  assign idle = mode_reg[MODE_IDLE];
  assign power_down = mode_reg[MODE_POWER_DOWN];
  assign emulation_mode = mode_reg[MODE_EMULATION];
  assign code_table_read = mode_reg[MODE_CODE_TABLE];
  assign lock_any = mode_reg[MODE_LOCK1] | mode_reg[MODE_LOCK2];
  // latched copy only counts once a lock bit is set
  assign external_fetch_select = lock_any ? fetch_latch_reg : fetch_pin_sync;
  assign ext_exec = !external_fetch_select || (fetch_addr_reg > INTERNAL_TOP);
  assign is_fetch = (cyc_reg == CYC_FETCH);
  assign is_xdata = (cyc_reg == CYC_XDATA);
  assign half = (phase_reg >= PH_HALF);
  assign q = half ? phase_reg - PH_HALF : phase_reg;
  assign strobe_off = strobe_ctrl_reg[CTRL_STROBE_OFF] && !ext_exec
    && !(is_xdata || code_table_read || idle || power_down || emulation_mode);

  // ----------------------------------------------------------------
  // fetch-select capture during reset
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fetch_latch_reg <= 1'b1;
    else if (core_reset)
      fetch_latch_reg <= fetch_pin_sync;
  end

  // ----------------------------------------------------------------
  // machine cycle timebase and cycle kind
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase_reg <= 4'h0;
      cyc_reg <= CYC_PLAIN;
    end
    else if (core_reset)
    begin
      phase_reg <= 4'h0;
      cyc_reg <= CYC_PLAIN;
    end
    else if (phase_reg == PH_LAST)
    begin
      phase_reg <= 4'h0;
      case (1'b1)
        busy_reg && !is_xdata: cyc_reg <= CYC_XDATA;
        ext_exec && !idle && !power_down && !emulation_mode: cyc_reg <= CYC_FETCH;
        default: cyc_reg <= CYC_PLAIN;
      endcase
    end
    else
      phase_reg <= phase_reg + 4'h1;
  end

  // ----------------------------------------------------------------
  // ahb-lite slave: zero wait states, always okay
  // ----------------------------------------------------------------
  logic take;
  logic [31:0] rd_mux;

  assign take = hsel && hready && htrans[1];

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (reg_index(haddr))
      IDX_PORT0: rd_mux = {24'h0, p0_latch_reg};
      IDX_PORT1: rd_mux = {24'h0, p1_latch_reg};
      IDX_PORT2: rd_mux = {24'h0, high_port_latch_reg};
      IDX_PORT3: rd_mux = {24'h0, p3_latch_reg};
      IDX_MODE: rd_mux = {24'h0, mode_reg};
      IDX_STROBE_CTRL: rd_mux = {24'h0, strobe_ctrl_reg};
      IDX_XCMD: rd_mux = {6'h0, xwide_reg, xwrite_reg, xwdata_reg, xaddr_reg};
      IDX_STATUS: rd_mux = {20'h0, core_reset, external_fetch_select, ext_exec,
                            busy_reg, xread_reg};
      IDX_FETCH: rd_mux = {8'h0, code_byte_reg, fetch_addr_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 10'h0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_reg <= take && hwrite;
      if (take)
        wr_idx_reg <= reg_index(haddr);
      if (take && !hwrite)
        hrdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // software registers; reset pin restores them, except mode bits 7:4 (lock bits)
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      strobe_ctrl_reg <= RST_STROBE_CTRL;
      mode_reg <= RST_MODE;
      p0_latch_reg <= RST_PORT_LATCH;
      p1_latch_reg <= RST_PORT_LATCH;
      high_port_latch_reg <= RST_PORT_LATCH;
      p3_latch_reg <= RST_PORT_LATCH;
    end
    else if (core_reset)
    begin
      strobe_ctrl_reg <= RST_STROBE_CTRL;
      // lock bits are non-volatile, only run modes clear
      mode_reg <= {mode_reg[7:4], 4'h0};
      p0_latch_reg <= RST_PORT_LATCH;
      p1_latch_reg <= RST_PORT_LATCH;
      high_port_latch_reg <= RST_PORT_LATCH;
      p3_latch_reg <= RST_PORT_LATCH;
    end
    else if (wr_pend_reg)
    begin
      case (wr_idx_reg)
        IDX_STROBE_CTRL: strobe_ctrl_reg <= hwdata[7:0];
        IDX_MODE: mode_reg <= hwdata[7:0];
        IDX_PORT0: p0_latch_reg <= hwdata[7:0];
        IDX_PORT1: p1_latch_reg <= hwdata[7:0];
        IDX_PORT2: high_port_latch_reg <= hwdata[7:0];
        IDX_PORT3: p3_latch_reg <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // external data move command and code fetch address
  // ----------------------------------------------------------------
  logic xdone;
  logic fetch_step;

  assign xdone = is_xdata && (phase_reg == PH_LAST);
  assign fetch_step = is_fetch && (q == Q_SAMPLE);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busy_reg <= 1'b0;
      xaddr_reg <= 16'h0000;
      xwdata_reg <= 8'h00;
      xwrite_reg <= 1'b0;
      xwide_reg <= 1'b0;
      xread_reg <= 8'h00;
    end
    else if (core_reset)
      busy_reg <= 1'b0;
    else
    begin
      // a command written while busy is dropped
      if (wr_pend_reg && wr_idx_reg == IDX_XCMD && !busy_reg)
      begin
        busy_reg <= 1'b1;
        xaddr_reg <= hwdata[15:0];
        xwdata_reg <= hwdata[XCMD_WDATA_LSB +: 8];
        xwrite_reg <= hwdata[XCMD_WRITE];
        xwide_reg <= hwdata[XCMD_WIDE];
      end
      else if (xdone)
        busy_reg <= 1'b0;
      if (is_xdata && !xwrite_reg && phase_reg == PH_XSTROBE_END)
        xread_reg <= p0_sync2_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fetch_addr_reg <= RST_FETCH_ADDR;
      code_byte_reg <= 8'h00;
    end
    else if (core_reset)
      fetch_addr_reg <= RST_FETCH_ADDR;
    else if (wr_pend_reg && wr_idx_reg == IDX_FETCH)
      fetch_addr_reg <= hwdata[15:0];
    else if (fetch_step)
    begin
      code_byte_reg <= p0_sync2_reg;
      fetch_addr_reg <= fetch_addr_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // strobe pins
  // ----------------------------------------------------------------
  logic strobe_slot;
  logic code_slot;

  // second pulse of a data move cycle is left out
  assign strobe_slot = (q < Q_STROBE_ON) && !(is_xdata && half);
  assign code_slot = is_fetch && (q >= Q_STROBE_ON);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      latch_strobe_program_pin_out <= 1'b0;
      latch_strobe_program_pin_oe <= 1'b1;
      latch_strobe_program_pin_pullup <= 1'b0;
      code_read_strobe_n_out <= 1'b1;
      code_read_strobe_n_oe <= 1'b1;
      code_read_strobe_n_pullup <= 1'b0;
    end
    else
    begin
      latch_strobe_program_pin_oe <= !strobe_off && !emulation_mode;
      latch_strobe_program_pin_pullup <= strobe_off || emulation_mode;
      code_read_strobe_n_oe <= !emulation_mode;
      code_read_strobe_n_pullup <= emulation_mode;
      if (power_down)
      begin
        latch_strobe_program_pin_out <= 1'b0;
        code_read_strobe_n_out <= 1'b0;
      end
      else if (idle)
      begin
        latch_strobe_program_pin_out <= 1'b1;
        code_read_strobe_n_out <= 1'b1;
      end
      else
      begin
        latch_strobe_program_pin_out <= strobe_slot && !strobe_off;
        code_read_strobe_n_out <= !code_slot;
      end
    end
  end

  // ----------------------------------------------------------------
  // ports
  // ----------------------------------------------------------------
  logic addr_slot;
  logic xstrobe;
  logic [15:0] bus_addr;

  assign addr_slot = (is_fetch && q < Q_STROBE_ON) || (is_xdata && phase_reg < Q_STROBE_ON);
  assign xstrobe = is_xdata && phase_reg >= Q_STROBE_ON && phase_reg <= PH_XSTROBE_END;
  assign bus_addr = is_xdata ? xaddr_reg : fetch_addr_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      port0_out <= 8'h00;
      port0_oe <= 8'h00;
    end
    else if (emulation_mode || ((idle || power_down) && ext_exec))
    begin
      port0_out <= 8'h00;
      port0_oe <= 8'h00;
    end
    else if (addr_slot)
    begin
      port0_out <= bus_addr[7:0];
      port0_oe <= 8'hff;
    end
    else if (xstrobe && xwrite_reg)
    begin
      port0_out <= xwdata_reg;
      port0_oe <= 8'hff;
    end
    else if (is_fetch || is_xdata)
    begin
      port0_out <= 8'h00;
      port0_oe <= 8'h00;
    end
    else
    begin
      port0_out <= 8'h00;
      port0_oe <= ~p0_latch_reg;
    end
  end

  // outside emulation, latch ones are weak pull-ups, zeros are driven, except port 2 address bytes and the port 3 strobe pin
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      port1_out <= 8'h00;
      port1_oe <= 8'h00;
      port1_pullup <= 8'hff;
      port2_out <= 8'h00;
      port2_oe <= 8'h00;
      port2_pullup <= 8'hff;
      port3_out <= 8'h00;
      port3_oe <= 8'h00;
      port3_pullup <= 8'hff;
    end
    else if (emulation_mode)
    begin
      port1_oe <= 8'h00;
      port1_pullup <= 8'hff;
      port2_oe <= 8'h00;
      port2_pullup <= 8'hff;
      port3_oe <= 8'h00;
      port3_pullup <= 8'hff;
    end
    else
    begin
      port1_out <= 8'h00;
      port1_oe <= ~p1_latch_reg;
      port1_pullup <= p1_latch_reg;
      if (is_fetch || (is_xdata && xwide_reg))
      begin
        port2_out <= bus_addr[15:8];
        port2_oe <= 8'hff;
        port2_pullup <= 8'h00;
      end
      else
      begin
        port2_out <= 8'h00;
        port2_oe <= ~high_port_latch_reg;
        port2_pullup <= high_port_latch_reg;
      end
      port3_out <= 8'h00;
      port3_oe <= ~p3_latch_reg;
      port3_pullup <= p3_latch_reg;
      if (xstrobe)
      begin
        port3_oe[xwrite_reg ? PIN_WRITE_STROBE : PIN_READ_STROBE] <= 1'b1;
        port3_pullup[xwrite_reg ? PIN_WRITE_STROBE : PIN_READ_STROBE] <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/bus_strobe_sva.sv */
// assertions on the strobe and port pins of the bus strobe block
// assumes one clock hclk; bound onto the block at the foot
`default_nettype none
module bus_strobe_sva
  import ext_bus_pkg::*;
(
  // clock and resets
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic reset_pin,
  // strobe pins
  input wire logic latch_strobe_program_pin_out,
  input wire logic latch_strobe_program_pin_oe,
  input wire logic latch_strobe_program_pin_pullup,
  input wire logic code_read_strobe_n_out,
  // ports
  input wire logic [7:0] port0_oe,
  input wire logic [7:0] port3_out,
  input wire logic [7:0] port3_oe
);
  timeunit 1ns / 1ps;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // a reset-pin pulse may cut any pattern short, so wait it out
  logic [3:0] calm;
  wire logic live = hresetn & (calm == 4'hf);
  wire logic ls = latch_strobe_program_pin_out;
  wire logic lo = latch_strobe_program_pin_oe;
  wire logic cs = code_read_strobe_n_out;
  wire logic rd = port3_oe[PIN_READ_STROBE] & ~port3_out[PIN_READ_STROBE];
  wire logic wr = port3_oe[PIN_WRITE_STROBE] & ~port3_out[PIN_WRITE_STROBE];
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      calm <= 4'h0;
    else if (reset_pin)
      calm <= 4'h0;
    else if (calm != 4'hf)
      calm <= calm + 4'h1;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!live);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_pulse;
    ls [*2] ##1 !ls [*4];
  endsequence
  sequence s_gap;
    !ls [*4] ##1 (ls or (!ls [*6] ##1 ls));
  endsequence
  sequence s_drop;
    ##[1:11] !lo;
  endsequence
  property p_pulse;
    $rose(ls) && lo && $past(lo) |-> s_pulse or s_drop;
  endproperty
  a_pulse: assert property (p_pulse) else $error("latch pulse malformed");
  property p_gap;
    $fell(ls) && lo && $past(lo) |-> s_gap or s_drop;
  endproperty
  a_gap: assert property (p_gap) else $error("latch pulse spacing wrong");
  property p_skip;
    $rose(rd | wr) |-> !ls [*8];
  endproperty
  a_skip: assert property (p_skip) else $error("latch pulse not skipped");
  property p_code;
    $fell(cs) |-> !cs [*4] ##1 cs;
  endproperty
  a_code: assert property (p_code) else $error("code strobe width wrong");
  property p_nocode;
    rd | wr |-> cs;
  endproperty
  a_nocode: assert property (p_nocode) else $error("code strobe in data move");
  property p_wrdrive;
    wr |-> port0_oe == 8'hff;
  endproperty
  a_wrdrive: assert property (p_wrdrive) else $error("port0 not driven");
  property p_excl;
    !(rd && wr);
  endproperty
  a_excl: assert property (p_excl) else $error("read and write strobes together");
  property p_pull;
    latch_strobe_program_pin_pullup == !lo;
  endproperty
  a_pull: assert property (p_pull) else $error("latch pull-up wrong");
endmodule
bind external_memory_bus bus_strobe_sva bus_strobe_sva_inst (.*);
`default_nettype wire

/* File: tb/ext_mem_model.sv */
// address latch with program and data memory behind it
// assumes the block's pin outputs; answers on port 0 without wait
`default_nettype none
module ext_mem_model
  import ext_bus_pkg::*;
(
  // clock
  input wire logic hclk,
  // strobes and buses from the block
  input wire logic latch_strobe_program_pin_out,
  input wire logic code_read_strobe_n_out,
  input wire logic [7:0] port0_out,
  input wire logic [7:0] port0_oe,
  input wire logic [7:0] port2_out,
  input wire logic [7:0] port2_oe,
  input wire logic [7:0] port2_pullup,
  input wire logic [7:0] port3_out,
  input wire logic [7:0] port3_oe,
  // level on the port 0 pins
  output logic [7:0] port0_in
);
  timeunit 1ns / 1ps;
  logic [7:0] mem [0:65535];
  logic [15:0] addr;
  logic [15:0] xaddr;
  logic [7:0] last = 8'h00;
  wire logic rd = port3_oe[PIN_READ_STROBE] & ~port3_out[PIN_READ_STROBE];
  wire logic wr = port3_oe[PIN_WRITE_STROBE] & ~port3_out[PIN_WRITE_STROBE];
  wire logic drive = rd | ~code_read_strobe_n_out;
  // undriven port 2 ones stand on their weak pull-ups
  wire logic [7:0] p2_pin = (port2_oe & port2_out) | (~port2_oe & port2_pullup);
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'ha5;
  end
  // no pull-up on port 0: a released bus shows the inverse of its last level
  assign port0_in = (port0_oe & port0_out) | (~port0_oe & (drive ? mem[addr] : ~last));
  always @(posedge hclk)
  begin
    last <= port0_in;
    if (latch_strobe_program_pin_out)
      addr <= {p2_pin, port0_out};
    if (rd | wr)
      xaddr <= addr;
    if (wr)
      mem[addr] <= port0_out;
  end
endmodule
`default_nettype wire

/* File: tb/test_external_memory_bus.sv */
// self-checking bench for the external memory bus strobe block
// assumes the block, its bound checker and the memory model
`default_nettype none
module test_external_memory_bus;
  timeunit 1ns / 1ps;
  import ext_bus_pkg::*;
  logic hclk, hresetn, hsel, hwrite, reset_pin, external_fetch_pin;
  logic [31:0] haddr, hwdata, hrdata, st;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp;
  logic latch_strobe_program_pin_out, latch_strobe_program_pin_oe;
  logic latch_strobe_program_pin_pullup;
  logic code_read_strobe_n_out, code_read_strobe_n_oe, code_read_strobe_n_pullup;
  logic [7:0] port0_in, port0_out, port0_oe, port1_out, port1_oe, port1_pullup;
  logic [7:0] port2_out, port2_oe, port2_pullup, port3_out, port3_oe, port3_pullup;
  wire logic hready = hreadyout;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  external_memory_bus external_memory_bus_inst (.*);
  ext_mem_model ext_mem_model_inst (.*);
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      results();
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic results;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0, idx, 2'b00};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    st = hrdata;
  endtask
  task automatic rd(input string what, input logic [9:0] idx, input logic [31:0] m,
                    input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    check(what, st & m, exp);
  endtask
  task automatic move(input logic [31:0] cmd);
    bus(1'b1, IDX_XCMD, cmd);
    do bus(1'b0, IDX_STATUS, 32'h0); while (st[STAT_BUSY] !== 1'b0);
  endtask
  // counts strobe starts at the pin, weak levels included
  task automatic count(input logic code);
    logic p;
    logic s;
    n = 0;
    for (int i = 0; i <= 120; i++)
    begin
      @(negedge hclk);
      if (code)
        s = !(code_read_strobe_n_oe ? code_read_strobe_n_out : code_read_strobe_n_pullup);
      else
        s = latch_strobe_program_pin_oe ? latch_strobe_program_pin_out
                                        : latch_strobe_program_pin_pullup;
      if (i > 0 && s && !p) n++;
      p = s;
    end
  endtask
  task automatic pin_pulse(input int len);
    @(posedge hclk);
    reset_pin <= 1'b1;
    repeat (len) @(posedge hclk);
    reset_pin <= 1'b0;
    repeat (8) @(posedge hclk);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {hresetn, hsel, hwrite, reset_pin, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    external_fetch_pin = 1'b1;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd("ctrl reset", IDX_STROBE_CTRL, 32'hff, 32'(RST_STROBE_CTRL));
    rd("unmapped", 10'h3ff, 32'hffffffff, 32'h0);
    check("port1 pullup", 32'(port1_pullup), 32'hff);
    count(1'b0);
    check("latch pulses", n, 32'd20);
    bus(1'b1, IDX_STROBE_CTRL, 32'h1);
    repeat (24) @(posedge hclk);
    check("latch oe stopped", 32'(latch_strobe_program_pin_oe), 32'h0);
    count(1'b0);
    check("stopped pulses", n, 32'd0);
    bus(1'b1, IDX_MODE, 32'h1 << MODE_CODE_TABLE);
    repeat (24) @(posedge hclk);
    check("latch suspended", 32'(latch_strobe_program_pin_oe), 32'h1);
    bus(1'b1, IDX_MODE, 32'h0);
    bus(1'b1, IDX_STROBE_CTRL, 32'h0);
    move(32'h0200_1234);
    check("wide data", st & 32'hff, 32'(ext_mem_model_inst.mem[16'h1234]));
    check("wide address", 32'(ext_mem_model_inst.xaddr), 32'h1234);
    bus(1'b1, IDX_PORT2, 32'h5a);
    move(32'h0000_0077);
    check("short address", 32'(ext_mem_model_inst.xaddr), 32'h5a77);
    move(32'h033c_0100);
    check("written byte", 32'(ext_mem_model_inst.mem[16'h0100]), 32'h3c);
    move(32'h0200_0100);
    check("read back", st & 32'hff, 32'h3c);
    bus(1'b1, IDX_PORT2, 32'hff);
    external_fetch_pin <= 1'b0;
    repeat (30) @(posedge hclk);
    count(1'b1);
    check("code strobes", n, 32'd20);
    bus(1'b1, IDX_STROBE_CTRL, 32'h1);
    repeat (24) @(posedge hclk);
    check("latch kept", 32'(latch_strobe_program_pin_oe), 32'h1);
    external_fetch_pin <= 1'b1;
    repeat (30) @(posedge hclk);
    count(1'b1);
    check("no code strobes", n, 32'd0);
    pin_pulse(10);
    rd("short pulse", IDX_STROBE_CTRL, 32'hff, 32'h1);
    pin_pulse(30);
    rd("reset pulse", IDX_STROBE_CTRL, 32'hff, 32'h0);
    bus(1'b1, IDX_MODE, 32'h1 << MODE_LOCK1);
    pin_pulse(30);
    external_fetch_pin <= 1'b0;
    repeat (4) @(posedge hclk);
    rd("latched select", IDX_STATUS, 32'h1 << STAT_FETCH_SEL, 32'h1 << STAT_FETCH_SEL);
    bus(1'b1, IDX_MODE, 32'h0);
    rd("free select", IDX_STATUS, 32'h1 << STAT_FETCH_SEL, 32'h0);
    external_fetch_pin <= 1'b1;
    repeat (30) @(posedge hclk);
    bus(1'b1, IDX_PORT0, 32'h0f);
    repeat (2) @(posedge hclk);
    check("port0 open drain", 32'(port0_oe), 32'hf0);
    results();
  end
endmodule
`default_nettype wire
